// [design/lic_pkg.sv]
package lic_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_DIAG  = 8'h00;
  localparam logic [7:0] REG_CTRL  = 8'h01;
  localparam logic [7:0] CTRL_RST  = 8'h00;
  localparam logic [7:0] DIAG_RST  = 8'h00;
  localparam logic [7:0] UNMAPPED  = 8'h00;

  // ----------------------------------------------------------------
  // Framing and bus addresses
  // ----------------------------------------------------------------
  localparam logic [3:0] LAST_BIT  = 4'h7;
  localparam logic [3:0] ACK_SLOT  = 4'h8;
  localparam logic [6:0] CHIP_ADR0 = 7'h08;
  localparam logic [6:0] CHIP_ADR1 = 7'h09;
  localparam int         BUF_DEPTH = 2;

  typedef enum logic [2:0]
  {
    LS_ADDR,
    LS_REG,
    LS_WDATA,
    LS_RDATA,
    LS_IGNORE
  } lic_link_e;

endpackage

// [design/lic_stream_if.sv]
interface lic_stream_if #(parameter int W = 8);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// [design/lic_fifo2.sv]
module lic_fifo2 #(
  parameter int W     = 8,
  parameter int DEPTH = lic_pkg::BUF_DEPTH
) (
  input  wire logic    i_clk,
  input  wire logic    i_sys_rst,
  lic_stream_if.snk    s_in,
  lic_stream_if.src    s_out
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
  localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

  logic [W-1:0]  mem [DEPTH];
  logic [PW-1:0] wr_ptr_reg;
  logic [PW-1:0] rd_ptr_reg;
  logic [CW-1:0] cnt_reg;

  wire push_w = s_in.valid & s_in.ready;
  wire pop_w  = s_out.valid & s_out.ready;
  wire [PW-1:0] wr_ptr_next = (wr_ptr_reg == PTR_LAST) ? '0 : wr_ptr_reg + 1'b1;
  wire [PW-1:0] rd_ptr_next = (rd_ptr_reg == PTR_LAST) ? '0 : rd_ptr_reg + 1'b1;
  wire [CW-1:0] cnt_next    = cnt_reg + CW'(push_w) - CW'(pop_w);

  assign s_in.ready  = (cnt_reg != CNT_FULL);
  assign s_out.valid = (cnt_reg != '0);
  assign s_out.data  = mem[rd_ptr_reg];

  always_ff @(posedge i_clk)
  begin
    if (push_w)
    begin
      mem[wr_ptr_reg] <= s_in.data;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      cnt_reg    <= '0;
    end
    else
    begin
      wr_ptr_reg <= push_w ? wr_ptr_next : wr_ptr_reg;
      rd_ptr_reg <= pop_w ? rd_ptr_next : rd_ptr_reg;
      cnt_reg    <= cnt_next;
    end
  end

endmodule

// [design/lic_i2c_slave.sv]
module lic_i2c_slave #(
  parameter logic [6:0] CHIP_ADR0 = lic_pkg::CHIP_ADR0,
  parameter logic [6:0] CHIP_ADR1 = lic_pkg::CHIP_ADR1,
  parameter int         BUF_DEPTH = lic_pkg::BUF_DEPTH
) (
  input  wire logic       i_clk,
  input  wire logic       i_sys_rst,
  input  wire logic       i_scl_clk,
  input  wire logic       i_sda_in,
  output logic            o_sda_out,
  output logic            o_sda_oe,
  input  wire logic       i_addr_sel,
  input  wire logic       i_uvlo,
  input  wire logic [7:0] i_diag,
  input  wire logic       i_ctrl_hold,
  output logic [7:0]      o_ctrl
);

  // ----------------------------------------------------------------
  // System domain: pin synchronisers and bus condition detection
  // ----------------------------------------------------------------
  // Start and stop happen while the serial clock is held high, so they
  // are seen here on oversampled copies of both lines. The link logic
  // is held in reset between a stop and the next start; this is what
  // ends a frame, because the serial clock stands still after a stop.

  logic       scl_meta_reg;
  logic       scl_sync_reg;
  logic       scl_prev_reg;
  logic       sda_meta_reg;
  logic       sda_sync_reg;
  logic       sda_prev_reg;
  logic       eng_rst_reg;
  logic       por_rst_reg;
  logic [7:0] diag_meta_reg;
  logic [7:0] diag_sync_reg;

  always_ff @(posedge i_clk)
  begin
    scl_meta_reg  <= i_scl_clk;
    scl_sync_reg  <= scl_meta_reg;
    scl_prev_reg  <= scl_sync_reg;
    sda_meta_reg  <= i_sda_in;
    sda_sync_reg  <= sda_meta_reg;
    sda_prev_reg  <= sda_sync_reg;
    diag_meta_reg <= i_diag;
    diag_sync_reg <= diag_meta_reg;
  end

  // A short bit pulse can put a fresh data level and a rising clock into
  // two neighbouring samples, which would look like a start or a stop.
  // Both samples must see the clock high, so only conditions inside a
  // long clock high phase are taken; ordinary bit pulses never qualify.
  wire scl_high_w = scl_sync_reg & scl_prev_reg;
  wire start_w    = scl_high_w & sda_prev_reg & ~sda_sync_reg;
  wire stop_w     = scl_high_w & ~sda_prev_reg & sda_sync_reg;

  // A stop forces the link logic idle, which also releases the data line.
  wire eng_rst_next = stop_w ? 1'b1 : (start_w ? 1'b0 : eng_rst_reg);

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      eng_rst_reg <= 1'b1;
      por_rst_reg <= 1'b1;
    end
    else
    begin
      eng_rst_reg <= eng_rst_next;
      por_rst_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // System domain: write crossing, buffer and control register
  // ----------------------------------------------------------------

  logic       wtog_meta_reg;
  logic       wtog_sync_reg;
  logic       wtog_seen_reg;
  logic [7:0] ctrl_reg;
  logic [7:0] wr_data_reg;
  logic       wr_tog_reg;
  logic       sda_out_reg;
  logic [15:0] shadow_reg;

  lic_stream_if #(.W(8)) fill_if ();
  lic_stream_if #(.W(8)) drain_if ();

  // The written byte stays still from the toggle until it is seen here.
  assign fill_if.valid  = (wtog_sync_reg != wtog_seen_reg);
  assign fill_if.data   = wr_data_reg;
  assign drain_if.ready = ~i_ctrl_hold;

  wire take_w = fill_if.valid & fill_if.ready;
  wire upd_w  = drain_if.valid & drain_if.ready;

  lic_fifo2 #(
    .W     (8),
    .DEPTH (BUF_DEPTH)
  ) u_wbuf (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .s_in      (fill_if),
    .s_out     (drain_if)
  );

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      wtog_meta_reg <= 1'b0;
      wtog_sync_reg <= 1'b0;
      wtog_seen_reg <= 1'b0;
      ctrl_reg      <= lic_pkg::CTRL_RST;
      sda_out_reg   <= 1'b0;
      shadow_reg    <= {lic_pkg::CTRL_RST, lic_pkg::DIAG_RST};
    end
    else
    begin
      wtog_meta_reg <= wr_tog_reg;
      wtog_sync_reg <= wtog_meta_reg;
      wtog_seen_reg <= take_w ? wtog_sync_reg : wtog_seen_reg;
      ctrl_reg      <= upd_w ? drain_if.data : ctrl_reg;
      sda_out_reg   <= 1'b0;
      // Read data is frozen while a frame runs, so the link sees a stable word.
      shadow_reg    <= eng_rst_reg ? {ctrl_reg, diag_sync_reg} : shadow_reg;
    end
  end

  assign o_ctrl    = ctrl_reg;
  assign o_sda_out = sda_out_reg;

  // ----------------------------------------------------------------
  // Link domain: level synchronisers and handshake return
  // ----------------------------------------------------------------

  logic uvlo_meta_reg;
  logic uvlo_sync_reg;
  logic sel_meta_reg;
  logic sel_sync_reg;
  logic ack_meta_reg;
  logic ack_sync_reg;

  always_ff @(posedge i_scl_clk or posedge eng_rst_reg)
  begin
    if (eng_rst_reg)
    begin
      uvlo_meta_reg <= 1'b0;
      uvlo_sync_reg <= 1'b0;
      sel_meta_reg  <= 1'b0;
      sel_sync_reg  <= 1'b0;
    end
    else
    begin
      uvlo_meta_reg <= i_uvlo;
      uvlo_sync_reg <= uvlo_meta_reg;
      sel_meta_reg  <= i_addr_sel;
      sel_sync_reg  <= sel_meta_reg;
    end
  end

  // ----------------------------------------------------------------
  // Link domain: byte framing and protocol state
  // ----------------------------------------------------------------
  // The data line is sampled on the rising serial clock edge, when the
  // master keeps it stable, and driven only after the falling edge.

  lic_pkg::lic_link_e state_reg;
  logic [3:0]         cnt_reg;
  logic [7:0]         shift_reg;
  logic [7:0]         tx_reg;
  logic               ack_reg;
  logic [7:0]         ptr_reg;

  wire       at_last_w = (cnt_reg == lic_pkg::LAST_BIT);
  wire       at_ack_w  = (cnt_reg == lic_pkg::ACK_SLOT);
  wire [7:0] byte_w    = {shift_reg[6:0], i_sda_in};
  wire [6:0] chip_w    = sel_sync_reg ? CHIP_ADR1 : CHIP_ADR0;
  wire       wr_busy_w = (wr_tog_reg != ack_sync_reg);
  wire       st_addr_w = (state_reg == lic_pkg::LS_ADDR);
  wire       st_reg_w  = (state_reg == lic_pkg::LS_REG);
  wire       st_wr_w   = (state_reg == lic_pkg::LS_WDATA);
  wire       st_rd_w   = (state_reg == lic_pkg::LS_RDATA);
  wire       adr_hit_w = (byte_w[7:1] == chip_w);

  // A write still pending at the crossing withholds the acknowledge, so the master sees it.
  wire ack_want_w = ~uvlo_sync_reg & ((st_addr_w & adr_hit_w) | st_reg_w
                                      | (st_wr_w & ~wr_busy_w));
  wire ack_next   = at_last_w ? ack_want_w : (ack_reg & ~at_ack_w);

  wire rd_go_w   = st_addr_w & ack_reg & shift_reg[0];
  wire rd_more_w = st_rd_w & ~i_sda_in;
  wire load_w    = at_ack_w & (rd_go_w | rd_more_w);
  wire set_ptr_w = at_ack_w & st_reg_w & ack_reg;
  wire push_w    = at_ack_w & st_wr_w & ack_reg & (ptr_reg == lic_pkg::REG_CTRL);

  wire [7:0] tx_sel_w = (ptr_reg == lic_pkg::REG_DIAG) ? shadow_reg[7:0]
                      : (ptr_reg == lic_pkg::REG_CTRL) ? shadow_reg[15:8]
                      : lic_pkg::UNMAPPED;

  wire [3:0] cnt_next   = at_ack_w ? 4'h0 : cnt_reg + 4'h1;
  wire [7:0] shift_next = at_ack_w ? shift_reg : byte_w;
  wire [7:0] tx_next    = load_w ? tx_sel_w
                        : ((st_rd_w & ~at_ack_w) ? {tx_reg[6:0], 1'b0} : tx_reg);
  wire [7:0] ptr_next   = set_ptr_w ? shift_reg : (load_w ? ptr_reg + 8'h01 : ptr_reg);

  lic_pkg::lic_link_e state_next;

  always_comb
  begin
    state_next = state_reg;
    if (at_ack_w)
    begin
      case (state_reg)
        lic_pkg::LS_ADDR:
          state_next = ~ack_reg ? lic_pkg::LS_IGNORE
                     : (shift_reg[0] ? lic_pkg::LS_RDATA : lic_pkg::LS_REG);
        lic_pkg::LS_REG:
          state_next = ack_reg ? lic_pkg::LS_WDATA : lic_pkg::LS_IGNORE;
        lic_pkg::LS_WDATA:
          state_next = ack_reg ? lic_pkg::LS_WDATA : lic_pkg::LS_IGNORE;
        lic_pkg::LS_RDATA:
          state_next = i_sda_in ? lic_pkg::LS_IGNORE : lic_pkg::LS_RDATA;
        lic_pkg::LS_IGNORE:
          state_next = lic_pkg::LS_IGNORE;
        default:
          state_next = lic_pkg::LS_IGNORE;
      endcase
    end
  end

  always_ff @(posedge i_scl_clk or posedge eng_rst_reg)
  begin
    if (eng_rst_reg)
    begin
      state_reg <= lic_pkg::LS_ADDR;
      cnt_reg   <= 4'h0;
      shift_reg <= 8'h00;
      tx_reg    <= 8'h00;
      ack_reg   <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      shift_reg <= shift_next;
      tx_reg    <= tx_next;
      ack_reg   <= ack_next;
    end
  end

  // ----------------------------------------------------------------
  // Link domain: state that outlives a frame
  // ----------------------------------------------------------------
  // The register pointer and the write handshake survive the stop, so a
  // read frame starts at the register chosen by the previous write.

  always_ff @(posedge i_scl_clk or posedge por_rst_reg)
  begin
    if (por_rst_reg)
    begin
      ptr_reg      <= lic_pkg::REG_DIAG;
      wr_tog_reg   <= 1'b0;
      wr_data_reg  <= lic_pkg::CTRL_RST;
      ack_meta_reg <= 1'b0;
      ack_sync_reg <= 1'b0;
    end
    else
    begin
      ptr_reg      <= eng_rst_reg ? ptr_reg : ptr_next;
      wr_tog_reg   <= (push_w & ~eng_rst_reg) ? ~wr_tog_reg : wr_tog_reg;
      wr_data_reg  <= (push_w & ~eng_rst_reg) ? shift_reg : wr_data_reg;
      ack_meta_reg <= wtog_seen_reg;
      ack_sync_reg <= ack_meta_reg;
    end
  end

  // ----------------------------------------------------------------
  // Link domain: data line driver
  // ----------------------------------------------------------------
  // The driver only ever pulls low; a one bit leaves the line to the
  // pull-up. It changes after the falling clock edge, or at once when a stop resets the link logic.

  wire ack_drv_w = at_ack_w & ack_reg;
  wire rd_drv_w  = st_rd_w & ~at_ack_w & ~tx_reg[7];
  wire oe_next   = ack_drv_w | rd_drv_w;

  logic sda_oe_reg;

  always_ff @(negedge i_scl_clk or posedge eng_rst_reg)
  begin
    if (eng_rst_reg)
    begin
      sda_oe_reg <= 1'b0;
    end
    else
    begin
      sda_oe_reg <= oe_next;
    end
  end

  assign o_sda_oe = sda_oe_reg;

endmodule

// [verif/lic_i2c_slave_monitor.sv]
module lic_i2c_slave_monitor #(
  parameter logic [6:0] CHIP_ADR0 = lic_pkg::CHIP_ADR0,
  parameter logic [6:0] CHIP_ADR1 = lic_pkg::CHIP_ADR1
) (
  input  wire logic       i_clk,
  input  wire logic       i_sys_rst,
  input  wire logic       i_scl_clk,
  input  wire logic       i_sda_in,
  input  wire logic       o_sda_out,
  input  wire logic       o_sda_oe,
  input  wire logic       i_addr_sel,
  input  wire logic       i_uvlo,
  input  wire logic       i_ctrl_hold,
  input  wire logic [7:0] o_ctrl
);
  timeunit 1ns;
  timeprecision 100ps;

  // ----
  // Frame tracking
  // ----
  // A start toggles a flag on the data edge itself, since no clock edge marks it.
  logic       tog   = 1'b0;
  logic       seen  = 1'b0;
  logic       first = 1'b0;
  logic       rd    = 1'b0;
  logic       oe_r  = 1'b0;
  logic [3:0] cnt   = 4'h0;
  logic [7:0] sh    = 8'h00;
  wire  logic [6:0] own = i_addr_sel ? CHIP_ADR1 : CHIP_ADR0;

  always_ff @(negedge i_sda_in)
    if (i_scl_clk) tog <= ~tog;

  always_ff @(posedge i_scl_clk)
  begin
    oe_r <= o_sda_oe;
    sh   <= {sh[6:0], i_sda_in};
    cnt  <= (tog != seen || cnt == 4'h9) ? 4'h1 : cnt + 4'h1;
    seen <= tog;
    if (tog != seen) first <= 1'b1;
    else if (cnt == 4'h9) first <= 1'b0;
    if (first && cnt == 4'h8) rd <= sh[0];
  end

  sequence s_addr_end;
    first && cnt == 4'h8;
  endsequence

  sequence s_data_ack;
    !first && !rd && cnt == 4'h8 && o_sda_oe;
  endsequence

  a_out_never_high: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    !o_sda_out) else $error("data line driven high");
  a_oe_stable_high: assert property (@(negedge i_scl_clk) disable iff (i_sys_rst)
    o_sda_oe == oe_r) else $error("data drive moved while clock high");
  a_addr_miss_quiet: assert property (@(posedge i_scl_clk) disable iff (i_sys_rst)
    s_addr_end ##0 sh[7:1] != own |-> !o_sda_oe [*8]) else $error("foreign frame driven");
  a_addr_hit_ack: assert property (@(posedge i_scl_clk) disable iff (i_sys_rst)
    !i_uvlo [*4] ##0 s_addr_end ##0 sh[7:1] == own |-> o_sda_oe) else $error("own address no ack");
  a_uvlo_no_ack: assert property (@(posedge i_scl_clk) disable iff (i_sys_rst)
    i_uvlo [*4] |-> !o_sda_oe) else $error("ack during lockout");
  a_addr_byte_quiet: assert property (@(posedge i_scl_clk) disable iff (i_sys_rst)
    first && cnt != 4'h0 && cnt < 4'h8 |-> !o_sda_oe) else $error("drive in address bits");
  a_write_ack_release: assert property (@(posedge i_scl_clk) disable iff (i_sys_rst)
    s_data_ack |=> !o_sda_oe) else $error("ack held past its slot");
  a_ctrl_hold_freeze: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    i_ctrl_hold [*3] |-> $stable(o_ctrl)) else $error("control moved while held");
endmodule

bind lic_i2c_slave lic_i2c_slave_monitor #(.CHIP_ADR0(CHIP_ADR0), .CHIP_ADR1(CHIP_ADR1)) u_mon (
  .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_scl_clk(i_scl_clk), .i_sda_in(i_sda_in),
  .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe), .i_addr_sel(i_addr_sel), .i_uvlo(i_uvlo),
  .i_ctrl_hold(i_ctrl_hold), .o_ctrl(o_ctrl));

// [verif/lic_i2c_master_model.sv]
module lic_i2c_master_model (
  output logic      o_scl,
  output logic      o_pull,
  input  wire logic i_sda
);
  timeunit 1ns;
  timeprecision 100ps;

  // ----
  // Bus master
  // ----
  // The wire has a pull-up, so a released line reads high; lo stretches the low phase.
  int lo = 3;

  initial
  begin
    o_scl  = 1'b1;
    o_pull = 1'b0;
  end

  task automatic pulse(input logic b, output logic s);
    o_scl = 1'b0;
    #1 o_pull = ~b;
    #(lo - 1) o_scl = 1'b1;
    s = i_sda;
    #3;
  endtask

  task automatic start();
    o_pull = 1'b1;
    #24 o_scl = 1'b0;
    #24;
  endtask

  task automatic stop();
    o_scl = 1'b0;
    #1 o_pull = 1'b1;
    #23 o_scl = 1'b1;
    #24 o_pull = 1'b0;
    #24;
  endtask

  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) pulse(b[i], s);
    pulse(1'b1, s);
    ack = ~s;
  endtask

  task automatic get_byte(input logic more, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      pulse(1'b1, s);
      b[i] = s;
    end
    pulse(more, s);
  endtask
endmodule

// [verif/lic_i2c_slave_bench.sv]
module lic_i2c_slave_bench;
  timeunit 1ns;
  timeprecision 100ps;

  logic        i_clk = 1'b0;
  logic        i_sys_rst, i_addr_sel, i_uvlo, i_ctrl_hold;
  logic [7:0]  i_diag, o_ctrl, ctrl_exp;
  logic        o_sda_out, o_sda_oe, scl, m_pull;
  logic [7:0]  tx [5];
  logic [7:0]  rx [2];
  logic [4:0]  ak;
  logic [31:0] seed = 32'h0000004e;
  int          err_count = 0;
  int          cmp_count = 0;
  wire  logic  sda = ~((o_sda_oe & ~o_sda_out) | m_pull);

  always #2 i_clk = ~i_clk;

  lic_i2c_slave u_dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_scl_clk(scl), .i_sda_in(sda),
    .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe), .i_addr_sel(i_addr_sel), .i_uvlo(i_uvlo),
    .i_diag(i_diag), .i_ctrl_hold(i_ctrl_hold), .o_ctrl(o_ctrl));
  lic_i2c_master_model u_mst (.o_scl(scl), .o_pull(m_pull), .i_sda(sda));

  // ----
  // Helpers
  // ----
  function automatic logic [7:0] rnd8();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction

  function automatic logic [6:0] adr(input logic s);
    return s ? lic_pkg::CHIP_ADR1 : lic_pkg::CHIP_ADR0;
  endfunction

  function automatic logic [7:0] exp_rd(input logic [7:0] p);
    return (p == 8'h00) ? i_diag : (p == 8'h01) ? ctrl_exp : 8'h00;
  endfunction

  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge i_clk);
  endtask

  task automatic wait_ctrl();
    int n;
    n = 0;
    while (o_ctrl !== ctrl_exp && n < 200)
    begin
      idle(1);
      n++;
    end
    if (n == 200)
    begin
      err_count++;
      $display("wrong value at %0t: control never updated", $time);
      summarize();
    end
  endtask

  // Stops at the first refused byte, as a master may after a missing ack.
  task automatic frame_wr(input int n);
    logic s;
    ak = 5'h00;
    u_mst.start();
    for (int i = 0; i < n; i++)
    begin
      u_mst.put_byte(tx[i], s);
      ak[i] = s;
      if (!s) break;
    end
    u_mst.stop();
  endtask

  task automatic frame_rd(input logic [6:0] a);
    logic s;
    u_mst.start();
    u_mst.put_byte({a, 1'b1}, s);
    chk8({7'h00, s}, 8'h01);
    u_mst.get_byte(1'b0, rx[0]);
    u_mst.get_byte(1'b1, rx[1]);
    u_mst.stop();
  endtask

  initial
  begin
    i_sys_rst   = 1'b1;
    i_addr_sel  = 1'b0;
    i_uvlo      = 1'b0;
    i_ctrl_hold = 1'b0;
    i_diag      = 8'h00;
    ctrl_exp    = 8'h00;
    idle(2);
    i_sys_rst <= 1'b0;
    idle(4);
    chk8(o_ctrl, 8'h00);
    $display("test reset done");
    for (int s = 0; s < 2; s++)
    begin
      idle(2);
      i_addr_sel <= s[0];
      idle(8);
      tx[0] = {adr(s[0]), 1'b0};
      tx[1] = 8'h01;
      tx[2] = rnd8();
      ctrl_exp = tx[2];
      frame_wr(3);
      chk8({3'h0, ak}, 8'h07);
      wait_ctrl();
      tx[0] = {adr(~s[0]), 1'b0};
      frame_wr(3);
      chk8({3'h0, ak}, 8'h00);
      tx[0] = {adr(s[0]), 1'b0};
      tx[1] = 8'h05;
      frame_wr(3);
      chk8({3'h0, ak}, 8'h07);
      idle(30);
      chk8(o_ctrl, ctrl_exp);
    end
    $display("test address done");
    for (int i = 0; i < 6; i++)
    begin
      idle(2);
      i_diag <= rnd8();
      idle(8);
      tx[1] = 8'(i % 3);
      frame_wr(2);
      chk8({3'h0, ak}, 8'h03);
      frame_rd(adr(i_addr_sel));
      chk8(rx[0], exp_rd(tx[1]));
      chk8(rx[1], exp_rd(tx[1] + 8'h01));
    end
    $display("test read done");
    idle(2);
    i_uvlo <= 1'b1;
    idle(8);
    tx[1] = 8'h01;
    tx[2] = rnd8();
    frame_wr(3);
    chk8({3'h0, ak}, 8'h00);
    chk8(o_ctrl, ctrl_exp);
    $display("test lockout done");
    idle(2);
    i_uvlo      <= 1'b0;
    i_ctrl_hold <= 1'b1;
    idle(8);
    u_mst.lo = 9;
    for (int i = 2; i < 5; i++) tx[i] = rnd8();
    // Two buffer entries and the word parked at the crossing are taken.
    frame_wr(5);
    chk8({3'h0, ak}, 8'h1f);
    // With the crossing still pending, the next data byte is refused.
    frame_wr(3);
    chk8({3'h0, ak}, 8'h03);
    idle(40);
    chk8(o_ctrl, ctrl_exp);
    chk8({6'h00, o_sda_out, o_sda_oe}, 8'h00);
    i_ctrl_hold <= 1'b0;
    ctrl_exp = tx[4];
    wait_ctrl();
    chk8(o_ctrl, ctrl_exp);
    $display("test stall done");
    summarize();
  end
endmodule
